// >>> common/ddx_pkg.sv
// Purpose: Shared constants and types for the second downconverter control bank
// Assumes: Byte-wide register port, one access per cycle
// Notes:   Offsets are byte addresses in the converter register space
package ddx_pkg;

   // Register offsets
   localparam logic [11:0] ADDR_EXT_DECIM   = 12'h0351;
   localparam logic [11:0] ADDR_OSC_CHAN    = 12'h0354;

   // Field positions
   localparam int EXT_DECIM_LSB = 4;
   localparam int EXT_DECIM_MSB = 7;
   localparam int MODE_LSB      = 4;
   localparam int MODE_MSB      = 7;
   localparam int CHAN_LSB      = 0;
   localparam int CHAN_MSB      = 3;

   // Reset values
   localparam logic [7:0] EXT_DECIM_RESET = 8'h00;
   localparam logic [7:0] OSC_CHAN_RESET  = 8'h00;
   localparam logic [7:0] RSVD_READ       = 8'h00;

   // Basic select code that hands over to the extended field
   localparam logic [2:0] BASIC_USE_EXT   = 3'h7;

   // Extended decimation codes
   localparam logic [3:0] EXT_TB_HB4321   = 4'h0;
   localparam logic [3:0] EXT_FB_HB1      = 4'h2;
   localparam logic [3:0] EXT_FB_HB21     = 4'h3;
   localparam logic [3:0] EXT_FB_HB321    = 4'h4;

   // Decimation totals for complex and real output
   localparam logic [5:0] DEC_48 = 6'h30;
   localparam logic [5:0] DEC_24 = 6'h18;
   localparam logic [5:0] DEC_20 = 6'h14;
   localparam logic [5:0] DEC_10 = 6'h0A;
   localparam logic [5:0] DEC_5  = 6'h05;
   localparam logic [5:0] DEC_40 = 6'h28;
   localparam logic [5:0] DEC_0  = 6'h00;

   // Channel select modes
   localparam logic [3:0] MODE_REG   = 4'h0;
   localparam logic [3:0] MODE_PINS  = 4'h1;
   localparam logic [3:0] MODE_EDGE1 = 4'h8;
   localparam logic [3:0] MODE_EDGE2 = 4'hA;

   // Filter enables of the decimation chain
   typedef struct packed {
      logic fifthband_stage;
      logic thirdband_stage;
      logic halfband_stage_four;
      logic halfband_stage_three;
      logic halfband_stage_two;
      logic halfband_stage_one;
   } ddx_filters_t;

   // Register bus request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } ddx_req_t;

endpackage : ddx_pkg

// >>> design/ddx_ctrl.sv
// Purpose: Extended decimation and oscillator channel select for downconverter two
// Assumes: Pins synchronous-ish to clk_sys but still synchronised here
// Notes:   Read data appears one cycle after the read strobe
`timescale 1ns/1ps

// What this block does
// RULE_01: The extended decimation field acts only when the basic decimation select is 111.
// RULE_02: Extended code 0 chains the third-band and all four half-band stages, decimating by 48 or 24 when real.
// RULE_03: Extended code 2 chains the fifth-band and first half-band stages, decimating by 10 or 5 when real.
// RULE_04: Extended code 3 adds the second half-band stage, decimating by 20 or 10 when real.
// RULE_05: Extended code 4 adds the third half-band stage, decimating by 40 or 20 when real.
// RULE_06: In edge modes the channel counter wraps to zero after reaching the register channel field.
// RULE_07: In mode 1 the channel is two zero bits above pin two and pin one.
// RULE_08: The counter steps on each rising edge of pin one in mode 8 or pin two in mode 10.
// RULE_09: In mode 0 the channel is the four-bit register channel field.
// RULE_10: With complex-to-real clear both outputs are valid, when set only the real output with a quarter-rate mix.
// RULE_11: Pins are synchronised and rising edges found from the synchronised levels so each edge counts once.
// RULE_12: Reserved bits read zero and ignore writes, and every field resets to zero.
module ddx_ctrl #(
   parameter int CHAN_W = 4
) (
   // Clock, reset, enable
   input  wire logic               clk_sys,
   input  wire logic               reset,
   input  wire logic               clk_en,
   // Register port
   input  wire ddx_pkg::ddx_req_t  req,
   output logic [7:0]              rdata,
   output logic                    rvalid,
   // Basic controls from the downconverter control register
   input  wire logic [2:0]         basic_decim_sel,
   input  wire logic               complex_to_real,
   // External pins
   input  wire logic               aux_pin_one,
   input  wire logic               aux_pin_two,
   // Results
   output ddx_pkg::ddx_filters_t   filters,
   output logic [5:0]              decim_total,
   output logic                    ext_active,
   output logic                    quad_valid,
   output logic                    quarter_mix_en,
   output logic [CHAN_W-1:0]       numeric_oscillator_chan
);

   logic [3:0]        ext_decim_reg;
   logic [3:0]        mode_reg;
   logic [CHAN_W-1:0] chan_field_reg;
   logic [1:0]        pin_meta_reg;
   logic [1:0]        pin_sync_reg;
   logic [1:0]        pin_last_reg;
   logic [CHAN_W-1:0] count_reg;
   logic [CHAN_W-1:0] count_next;
   logic              step;
   logic              edge_mode;
   ddx_pkg::ddx_filters_t filt_next;
   logic [5:0]        total_next;
   logic [CHAN_W-1:0] chan_next;

   // Register writes, reserved low nibble of extended register dropped
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         ext_decim_reg  <= ddx_pkg::EXT_DECIM_RESET[ddx_pkg::EXT_DECIM_MSB:ddx_pkg::EXT_DECIM_LSB]; // see RULE_12
         mode_reg       <= ddx_pkg::OSC_CHAN_RESET[ddx_pkg::MODE_MSB:ddx_pkg::MODE_LSB];
         chan_field_reg <= CHAN_W'(ddx_pkg::OSC_CHAN_RESET[ddx_pkg::CHAN_MSB:ddx_pkg::CHAN_LSB]);
      end else if (clk_en && req.wr) begin
         if (req.addr == ddx_pkg::ADDR_EXT_DECIM) begin
            ext_decim_reg <= req.wdata[ddx_pkg::EXT_DECIM_MSB:ddx_pkg::EXT_DECIM_LSB]; // see RULE_12
         end
         if (req.addr == ddx_pkg::ADDR_OSC_CHAN) begin
            mode_reg       <= req.wdata[ddx_pkg::MODE_MSB:ddx_pkg::MODE_LSB];
            chan_field_reg <= CHAN_W'(req.wdata[ddx_pkg::CHAN_MSB:ddx_pkg::CHAN_LSB]);
         end
      end
   end

   // Read data, unmapped addresses read zero
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         rdata  <= ddx_pkg::RSVD_READ;
         rvalid <= 1'b0;
      end else if (clk_en) begin
         rvalid <= req.rd;
         if (req.rd && req.addr == ddx_pkg::ADDR_EXT_DECIM) begin
            rdata <= {ext_decim_reg, ddx_pkg::RSVD_READ[3:0]}; // see RULE_12
         end else if (req.rd && req.addr == ddx_pkg::ADDR_OSC_CHAN) begin
            rdata <= {mode_reg, 4'(chan_field_reg)};
         end else begin
            rdata <= ddx_pkg::RSVD_READ;
         end
      end
   end

   // Pin synchronisers; first stage feeds only the second
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pin_meta_reg <= 2'h0;
         pin_sync_reg <= 2'h0;
         pin_last_reg <= 2'h0;
      end else if (clk_en) begin
         pin_meta_reg <= {aux_pin_two, aux_pin_one};
         pin_sync_reg <= pin_meta_reg; // see RULE_11
         pin_last_reg <= pin_sync_reg;
      end
   end

   // Edge selection for counting modes
   always_comb begin
      edge_mode = (mode_reg == ddx_pkg::MODE_EDGE1) || (mode_reg == ddx_pkg::MODE_EDGE2);
      step = 1'b0;
      if (mode_reg == ddx_pkg::MODE_EDGE1) begin
         step = pin_sync_reg[0] && !pin_last_reg[0]; // see RULE_08
      end else if (mode_reg == ddx_pkg::MODE_EDGE2) begin
         step = pin_sync_reg[1] && !pin_last_reg[1]; // see RULE_08
      end
      count_next = count_reg;
      if (step) begin
         if (count_reg >= chan_field_reg) begin
            count_next = '0; // see RULE_06
         end else begin
            count_next = count_reg + CHAN_W'(1);
         end
      end
   end

   // Internal channel counter
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         count_reg <= '0;
      end else if (clk_en) begin
         count_reg <= count_next;
      end
   end

   // Active channel choice
   always_comb begin
      chan_next = chan_field_reg; // see RULE_09
      if (mode_reg == ddx_pkg::MODE_PINS) begin
         chan_next = CHAN_W'({2'h0, pin_sync_reg[1], pin_sync_reg[0]}); // see RULE_07
      end else if (edge_mode) begin
         chan_next = count_reg;
      end
   end

   // Filter chain from the extended code
   always_comb begin
      filt_next  = '0;
      total_next = ddx_pkg::DEC_0;
      if (basic_decim_sel == ddx_pkg::BASIC_USE_EXT) begin // see RULE_01
         unique case (ext_decim_reg)
            ddx_pkg::EXT_TB_HB4321: begin
               filt_next = '{fifthband_stage: 1'b0, thirdband_stage: 1'b1, halfband_stage_four: 1'b1,
                             halfband_stage_three: 1'b1, halfband_stage_two: 1'b1, halfband_stage_one: 1'b1};
               total_next = complex_to_real ? ddx_pkg::DEC_24 : ddx_pkg::DEC_48; // see RULE_02
            end
            ddx_pkg::EXT_FB_HB1: begin
               filt_next.fifthband_stage    = 1'b1;
               filt_next.halfband_stage_one = 1'b1;
               total_next = complex_to_real ? ddx_pkg::DEC_5 : ddx_pkg::DEC_10; // see RULE_03
            end
            ddx_pkg::EXT_FB_HB21: begin
               filt_next.fifthband_stage    = 1'b1;
               filt_next.halfband_stage_two = 1'b1;
               filt_next.halfband_stage_one = 1'b1;
               total_next = complex_to_real ? ddx_pkg::DEC_10 : ddx_pkg::DEC_20; // see RULE_04
            end
            ddx_pkg::EXT_FB_HB321: begin
               filt_next.fifthband_stage      = 1'b1;
               filt_next.halfband_stage_three = 1'b1;
               filt_next.halfband_stage_two   = 1'b1;
               filt_next.halfband_stage_one   = 1'b1;
               total_next = complex_to_real ? ddx_pkg::DEC_20 : ddx_pkg::DEC_40; // see RULE_05
            end
            default: begin
               filt_next  = '0;
               total_next = ddx_pkg::DEC_0;
            end
         endcase
      end
   end

   // Registered outputs
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         filters                 <= '0;
         decim_total             <= ddx_pkg::DEC_0;
         ext_active              <= 1'b0;
         quad_valid              <= 1'b1;
         quarter_mix_en          <= 1'b0;
         numeric_oscillator_chan <= '0;
      end else if (clk_en) begin
         filters                 <= filt_next;
         decim_total             <= total_next;
         ext_active              <= (basic_decim_sel == ddx_pkg::BASIC_USE_EXT);
         quad_valid              <= !complex_to_real; // see RULE_10
         quarter_mix_en          <= complex_to_real; // see RULE_10
         numeric_oscillator_chan <= chan_next;
      end
   end

   // Extended code ignored unless basic select is 111
   a_ext_gate: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_01
      clk_en && basic_decim_sel != ddx_pkg::BASIC_USE_EXT |=> decim_total == ddx_pkg::DEC_0 && filters == '0)
      else $error("extended field acted without basic 111");

   a_code0_total: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_02
      clk_en && basic_decim_sel == ddx_pkg::BASIC_USE_EXT && ext_decim_reg == ddx_pkg::EXT_TB_HB4321
      |=> decim_total == ($past(complex_to_real) ? ddx_pkg::DEC_24 : ddx_pkg::DEC_48))
      else $error("code 0 total wrong");

   a_code2_total: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_03
      clk_en && basic_decim_sel == ddx_pkg::BASIC_USE_EXT && ext_decim_reg == ddx_pkg::EXT_FB_HB1 && !complex_to_real
      |=> decim_total == ddx_pkg::DEC_10 && filters.fifthband_stage)
      else $error("code 2 total wrong");

   a_code3_total: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_04
      clk_en && basic_decim_sel == ddx_pkg::BASIC_USE_EXT && ext_decim_reg == ddx_pkg::EXT_FB_HB21 && !complex_to_real
      |=> decim_total == ddx_pkg::DEC_20)
      else $error("code 3 total wrong");

   a_code4_total: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_05
      clk_en && basic_decim_sel == ddx_pkg::BASIC_USE_EXT && ext_decim_reg == ddx_pkg::EXT_FB_HB321 && !complex_to_real
      |=> decim_total == ddx_pkg::DEC_40 && filters.halfband_stage_three)
      else $error("code 4 total wrong");

   a_count_wrap: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_06
      clk_en && step && count_reg >= chan_field_reg |=> count_reg == '0)
      else $error("counter failed to wrap");

   a_count_step: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_08
      clk_en && step && count_reg < chan_field_reg |=> count_reg == $past(count_reg) + CHAN_W'(1))
      else $error("counter failed to step");

   a_reg_chan: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_09
      clk_en && mode_reg == ddx_pkg::MODE_REG |=> numeric_oscillator_chan == $past(chan_field_reg))
      else $error("register channel not used");

   a_real_mode: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_10
      clk_en |=> quarter_mix_en == $past(complex_to_real) && quad_valid == !$past(complex_to_real))
      else $error("real mode outputs inconsistent");

   // Pin mode channel follows the synchronised pin levels
   a_pin_chan: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_07
      clk_en && mode_reg == ddx_pkg::MODE_PINS |=> numeric_oscillator_chan == CHAN_W'({2'h0, $past(pin_sync_reg)}))
      else $error("pin channel not used");

   // Low enable freezes counter and outputs
   a_freeze_hold: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_08
      !clk_en |=> $stable(count_reg) && $stable(numeric_oscillator_chan) && $stable(decim_total)
      && $stable(quarter_mix_en))
      else $error("state moved while enable low");

   a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (reset) // see RULE_12
      clk_en && req.rd && req.addr == ddx_pkg::ADDR_EXT_DECIM |=> rdata[3:0] == 4'h0 && rvalid)
      else $error("reserved bits not zero");

endmodule : ddx_ctrl

// >>> testbench/ddx_pin_model.sv
// Purpose: Far-side logic that drives the two auxiliary pins
// Assumes: Bench asks for pin levels; model moves pins after a falling edge
// Notes:   Push-pull levels, so a held level is a real level
`timescale 1ns/1ps
module ddx_pin_model (
   // Clock
   input  wire logic       clk_sys,
   // Levels asked for by the bench
   input  wire logic [1:0] want,
   // Pins toward the device
   output logic            aux_pin_one = 1'b0,
   output logic            aux_pin_two = 1'b0
);
   // Pins change away from the sampling edge
   always @(negedge clk_sys) begin
      aux_pin_one <= want[0];
      aux_pin_two <= want[1];
   end
endmodule : ddx_pin_model

// >>> testbench/ddc2_decim_nco_channel_select_test.sv
// Purpose: Self-checking bench for the decimation and channel select bank
// Assumes: Inputs driven at falling edges, fixed random seed
// Notes:   Expectations come from the bench function dexp, the pulse task and bench constants only
`timescale 1ns/1ps
module ddc2_decim_nco_channel_select_test;
   logic                  clk_sys = 1'b0;
   logic                  reset   = 1'b1;
   ddx_pkg::ddx_req_t     req     = '0;
   logic [2:0]            bsel    = 3'h0;
   logic                  c2r     = 1'b0;
   logic                  en      = 1'b1;
   logic [1:0]            want    = 2'b00;
   logic [7:0]            rdata;
   logic                  rvalid, ext_active, quad_valid, quarter_mix_en, pin_one, pin_two;
   ddx_pkg::ddx_filters_t filters;
   logic [5:0]            decim_total;
   logic [3:0]            chan;
   logic [11:0]           e;
   int                    errors = 0;
   int                    comparisons = 0;
   int                    cnt = 0;
   int                    lim;
   logic [3:0]            m;

   // Clock at 200 MHz
   always #2.5 clk_sys = ~clk_sys;

   ddx_pin_model pin_u (.clk_sys(clk_sys), .want(want), .aux_pin_one(pin_one), .aux_pin_two(pin_two));

   ddx_ctrl dut_u (.clk_sys(clk_sys), .reset(reset), .clk_en(en), .req(req), .rdata(rdata), .rvalid(rvalid),
      .basic_decim_sel(bsel), .complex_to_real(c2r), .aux_pin_one(pin_one), .aux_pin_two(pin_two),
      .filters(filters), .decim_total(decim_total), .ext_active(ext_active), .quad_valid(quad_valid),
      .quarter_mix_en(quarter_mix_en), .numeric_oscillator_chan(chan));

   task automatic finish_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : finish_test

   task automatic chk(input string nm, input logic [7:0] x, input logic [7:0] got);
      comparisons++;
      if (got !== x) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, x, got);
      end
   endtask : chk

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : cyc

   // Write strobe for one cycle, then let outputs settle
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      cyc(1);
      req <= '0;
      cyc(2);
   endtask : wr

   // Read strobe; answer stands in the following cycle
   task automatic rd(input logic [11:0] a, input logic [7:0] x);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      cyc(1);
      req <= '0;
      chk("rvalid", 8'h01, {7'h00, rvalid});
      chk("rdata", x, rdata);
      cyc(1);
   endtask : rd

   // Pin pulse held several cycles; model steps only on the matching pin
   task automatic pulse(input int p);
      want[p] <= 1'b1;
      cyc(5);
      want[p] <= 1'b0;
      cyc(5);
      if ((m == ddx_pkg::MODE_EDGE1 && p == 0) || (m == ddx_pkg::MODE_EDGE2 && p == 1))
         cnt = (cnt >= lim) ? 0 : cnt + 1;
   endtask : pulse

   // Expected filters and total for one setting
   function automatic logic [11:0] dexp(input logic [2:0] b, input logic [3:0] c, input logic r);
      logic [11:0] v;
      v = 12'h000;
      if (b == 3'h7) begin
         case (c)
            4'h0: v = {6'h1f, 6'h30};
            4'h2: v = {6'h21, 6'h0a};
            4'h3: v = {6'h23, 6'h14};
            4'h4: v = {6'h27, 6'h28};
            default: v = 12'h000;
         endcase
      end
      if (r) v[5:0] = v[5:0] >> 1;
      return v;
   endfunction : dexp

   // Hang guard
   initial begin
      for (int t = 0; t < 60000; t++) @(posedge clk_sys);
      errors++;
      $display("wrong value run_length expected done seen timeout");
      finish_test();
   end

   initial begin
      void'($urandom(32'h1bab_861f));
      cyc(8);
      reset <= 1'b0;
      cyc(1);
      chk("chan", 8'h00, {4'h0, chan});
      chk("quad", 8'h01, {7'h00, quad_valid});
      rd(ddx_pkg::ADDR_EXT_DECIM, 8'h00);
      rd(ddx_pkg::ADDR_OSC_CHAN, 8'h00);
      rd(12'h0352, 8'h00);
      $display("test reset done");
      for (int c = 0; c < 16; c++) begin
         wr(ddx_pkg::ADDR_EXT_DECIM, {c[3:0], 4'hf});
         rd(ddx_pkg::ADDR_EXT_DECIM, {c[3:0], 4'h0});
         for (int r = 0; r < 2; r++) begin
            c2r <= r[0];
            bsel <= (r == 0) ? 3'h7 : 3'($urandom_range(6));
            cyc(3);
            e = dexp(bsel, c[3:0], r[0]);
            chk("decim", {2'b00, e[5:0]}, {2'b00, decim_total});
            chk("ext", {7'h00, bsel == 3'h7}, {7'h00, ext_active});
            chk("quarter", {7'h00, r[0]}, {7'h00, quarter_mix_en});
            chk("quad", {7'h00, ~r[0]}, {7'h00, quad_valid});
            bsel <= 3'h7;
            cyc(3);
            e = dexp(3'h7, c[3:0], r[0]);
            chk("filters", {2'b00, e[11:6]}, {2'b00, filters});
            chk("decim7", {2'b00, e[5:0]}, {2'b00, decim_total});
         end
      end
      $display("test decimation done");
      for (int k = 0; k < 6; k++) begin
         e[3:0] = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom_range(15));
         wr(ddx_pkg::ADDR_OSC_CHAN, {ddx_pkg::MODE_REG, e[3:0]});
         chk("chan", {4'h0, e[3:0]}, {4'h0, chan});
         rd(ddx_pkg::ADDR_OSC_CHAN, {ddx_pkg::MODE_REG, e[3:0]});
      end
      wr(ddx_pkg::ADDR_OSC_CHAN, {4'h3, e[3:0]});
      wr(12'h0355, 8'h5a);
      chk("chan_fallback", {4'h0, e[3:0]}, {4'h0, chan});
      rd(ddx_pkg::ADDR_OSC_CHAN, {4'h3, e[3:0]});
      wr(ddx_pkg::ADDR_OSC_CHAN, {ddx_pkg::MODE_PINS, 4'($urandom_range(15))});
      for (int p = 0; p < 4; p++) begin
         want <= p[1:0];
         cyc(6);
         chk("pins", {6'h00, p[1:0]}, {4'h0, chan});
      end
      want <= 2'b00;
      cyc(6);
      $display("test register and pin modes done");
      for (int s = 0; s < 2; s++) begin
         m = (s == 0) ? ddx_pkg::MODE_EDGE1 : ddx_pkg::MODE_EDGE2;
         lim = (s == 0) ? $urandom_range(5, 2) : 1;
         wr(ddx_pkg::ADDR_OSC_CHAN, {m, 4'(lim)});
         for (int k = 0; k < 2 * lim + 6; k++) begin
            pulse($urandom_range(1));
            chk("count", 8'(cnt), {4'h0, chan});
         end
      end
      $display("test edge modes done");
      en <= 1'b0;
      c2r <= 1'b0;
      cyc(1);
      wr(ddx_pkg::ADDR_OSC_CHAN, 8'h00);
      chk("chan_frozen", 8'(cnt), {4'h0, chan});
      chk("quarter_frozen", 8'h01, {7'h00, quarter_mix_en});
      en <= 1'b1;
      cyc(3);
      rd(ddx_pkg::ADDR_OSC_CHAN, {m, 4'(lim)});
      chk("quarter", 8'h00, {7'h00, quarter_mix_en});
      $display("test clock enable done");
      finish_test();
   end
endmodule : ddc2_decim_nco_channel_select_test
